// [design/mfpc_top.v]
// Purpose: Function, driver and level logic for a bidirectional and an output-only general pin
// Assumes: Simple 8-bit register port: address, write strobe, write data, read data
// Notes: Interrupt and pulse density clock are produced elsewhere and routed in here
`timescale 1ns/1ps
`include "mfpc_defs.vh"

module mfpc_top (
	// Clock and reset
	input  wire       mclk_in,
	input  wire       rst_in,
	// Register port
	input  wire [7:0] reg_addr_in,
	input  wire       reg_wr_in,
	input  wire [7:0] reg_wdata_in,
	output reg  [7:0] reg_rdata_out,
	// Internal sources for output roles
	input  wire       irq_event_in,
	input  wire       interrupt_polarity_in,
	input  wire       pulse_density_clock_in,
	// Bidirectional pin pad
	input  wire       bidir_pin_in,
	output wire       bidir_pin_out,
	output wire       bidir_pin_oe_out,
	output wire       bidir_pin_weak_oe_out,
	// Output-only pin pad
	output wire       out_only_pin_out,
	output wire       out_only_pin_oe_out,
	output wire       out_only_pin_weak_oe_out,
	// Input role results
	output reg        adc_powerdown_out,
	output reg        mic_bias_switch_in_out,
	output reg        master_clock_out,
	output reg        serial_audio_in_out,
	output reg        pulse_density_data_a_out,
	output reg        pulse_density_data_b_out
);

	// Configuration registers
	reg  [7:0] multi_pin_config_q;
	reg  [7:0] out_pin_config_q;
	reg  [7:0] pin_output_levels_q;
	reg        bidir_pin_in_level_q;

	wire       bidir_sync;

	wire [3:0] bidir_pin_function_sel = multi_pin_config_q[`MFPC_FUNC_HI:`MFPC_FUNC_LO];
	wire [2:0] bidir_pin_drive_sel    = multi_pin_config_q[`MFPC_DRV_HI:`MFPC_DRV_LO];
	wire [3:0] out_pin_function_sel   = out_pin_config_q[`MFPC_FUNC_HI:`MFPC_FUNC_LO];
	wire [2:0] out_pin_drive_sel      = out_pin_config_q[`MFPC_DRV_HI:`MFPC_DRV_LO];
	wire       bidir_pin_out_level    = pin_output_levels_q[`MFPC_BIDIR_LEVEL_BIT];
	wire       out_pin_out_level      = pin_output_levels_q[`MFPC_OUT_LEVEL_BIT];

	// Interrupt level in the selected polarity
	wire       irq_level = interrupt_polarity_in ? irq_event_in : ~irq_event_in;

	// Keep only writable bits so reserved positions stay zero regardless of software
	function [7:0] mfpc_cfg_mask;
		input [7:0] wdata;
		begin
			mfpc_cfg_mask = {wdata[7:4], 1'b0, wdata[2:0]};
		end
	endfunction

	// Whether a function code is an output role the pad must drive
	function mfpc_is_out_role;
		input [3:0] fn;
		begin
			mfpc_is_out_role = (fn == `MFPC_FN_PLAIN_OUT) || (fn == `MFPC_FN_IRQ_OUT) ||
			                   (fn == `MFPC_FN_PDM_CLK_OUT);
		end
	endfunction

	// Level to present for an output role
	function mfpc_out_level;
		input [3:0] fn;
		input       plain_level;
		input       irq_lvl;
		input       pdm_clk;
		begin
			case (fn)
			`MFPC_FN_PLAIN_OUT:   mfpc_out_level = plain_level;
			`MFPC_FN_IRQ_OUT:     mfpc_out_level = irq_lvl;
			`MFPC_FN_PDM_CLK_OUT: mfpc_out_level = pdm_clk;
			default:              mfpc_out_level = 1'b0;
			endcase
		end
	endfunction

	// Register writes; function field written as given, reserved bit forced to zero
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			multi_pin_config_q  <= `MFPC_RST_MULTI_CFG;
			out_pin_config_q    <= `MFPC_RST_OUT_CFG;
			pin_output_levels_q <= `MFPC_RST_LEVELS;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
			`MFPC_ADDR_MULTI_CFG: begin
				multi_pin_config_q <= mfpc_cfg_mask(reg_wdata_in);
			end
			`MFPC_ADDR_OUT_CFG: begin
				out_pin_config_q <= mfpc_cfg_mask(reg_wdata_in);
			end
			`MFPC_ADDR_LEVELS: begin
				pin_output_levels_q <= {reg_wdata_in[7:6], 6'h00};
			end
			default: begin
				pin_output_levels_q <= pin_output_levels_q; // Unmapped and read-only: ignored
			end
			endcase
		end
	end

	// Synchronise the pad level before any role looks at it
	mfpc_sync3 u_bidir_sync (
		.mclk_in   (mclk_in),
		.rst_in    (rst_in),
		.async_in  (bidir_pin_in),
		.level_out (bidir_sync)
	);

	// Route the synchronised level to the input role selected; disabled uses nothing
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			adc_powerdown_out        <= 1'b0;
			mic_bias_switch_in_out   <= 1'b0;
			master_clock_out         <= 1'b0;
			serial_audio_in_out      <= 1'b0;
			pulse_density_data_a_out <= 1'b0;
			pulse_density_data_b_out <= 1'b0;
			bidir_pin_in_level_q     <= 1'b0;
		end else begin
			adc_powerdown_out        <= (bidir_pin_function_sel == `MFPC_FN_ADC_PWRDN)  & bidir_sync;
			mic_bias_switch_in_out   <= (bidir_pin_function_sel == `MFPC_FN_BIAS_SWITCH) & bidir_sync;
			master_clock_out         <= (bidir_pin_function_sel == `MFPC_FN_MCLK_IN)    & bidir_sync;
			serial_audio_in_out      <= (bidir_pin_function_sel == `MFPC_FN_SERIAL_IN)  & bidir_sync;
			pulse_density_data_a_out <= (bidir_pin_function_sel == `MFPC_FN_PDM_DATA_A) & bidir_sync;
			pulse_density_data_b_out <= (bidir_pin_function_sel == `MFPC_FN_PDM_DATA_B) & bidir_sync;
			// Monitor holds its last value when the pin leaves the plain input role
			if (bidir_pin_function_sel == `MFPC_FN_PLAIN_IN)
				bidir_pin_in_level_q <= bidir_sync;
		end
	end

	// Register read mux; unmapped offsets read zero
	always @* begin
		case (reg_addr_in)
		`MFPC_ADDR_MULTI_CFG: reg_rdata_out = multi_pin_config_q;
		`MFPC_ADDR_OUT_CFG:   reg_rdata_out = out_pin_config_q;
		`MFPC_ADDR_LEVELS:    reg_rdata_out = pin_output_levels_q;
		`MFPC_ADDR_MONITOR:   reg_rdata_out = {bidir_pin_in_level_q, 7'h00};
		default:              reg_rdata_out = 8'h00;
		endcase
	end

	// Bidirectional pad: only output roles drive; disabled and input roles release it
	mfpc_pin_driver u_bidir_drv (
		.active_in       (mfpc_is_out_role(bidir_pin_function_sel)),
		.drive_sel_in    (bidir_pin_drive_sel),
		.level_in        (mfpc_out_level(bidir_pin_function_sel, bidir_pin_out_level,
		                                 irq_level, pulse_density_clock_in)),
		.pin_out         (bidir_pin_out),
		.pin_oe_out      (bidir_pin_oe_out),
		.pin_weak_oe_out (bidir_pin_weak_oe_out)
	);

	// Output-only pad; its reserved driver styles fall to undriven in the driver
	mfpc_pin_driver u_out_drv (
		.active_in       (mfpc_is_out_role(out_pin_function_sel)),
		.drive_sel_in    ((out_pin_drive_sel == `MFPC_DRV_LOW_WEAKHI ||
		                   out_pin_drive_sel == `MFPC_DRV_WEAKLO_HIGH) ? `MFPC_DRV_HIZ : out_pin_drive_sel),
		.level_in        (mfpc_out_level(out_pin_function_sel, out_pin_out_level,
		                                 irq_level, pulse_density_clock_in)),
		.pin_out         (out_only_pin_out),
		.pin_oe_out      (out_only_pin_oe_out),
		.pin_weak_oe_out (out_only_pin_weak_oe_out)
	);

endmodule // mfpc_top

// [design/mfpc_defs.vh]
// Purpose: Register offsets, field positions and reset values for the multi-function pin block
// Assumes: 8-bit register port with 8-bit addresses
// Notes: Definitions only
`ifndef MFPC_DEFS_VH
`define MFPC_DEFS_VH

// Register offsets
`define MFPC_ADDR_MULTI_CFG   8'h21
`define MFPC_ADDR_OUT_CFG     8'h22
`define MFPC_ADDR_LEVELS      8'h29
`define MFPC_ADDR_MONITOR     8'h2A

// Reset values
`define MFPC_RST_MULTI_CFG    8'h22
`define MFPC_RST_OUT_CFG      8'h00
`define MFPC_RST_LEVELS       8'h00

// Field positions
`define MFPC_FUNC_HI          7
`define MFPC_FUNC_LO          4
`define MFPC_DRV_HI           2
`define MFPC_DRV_LO           0
`define MFPC_BIDIR_LEVEL_BIT  7
`define MFPC_OUT_LEVEL_BIT    6
`define MFPC_MON_BIT          7

// Function codes
`define MFPC_FN_DISABLED      4'h0
`define MFPC_FN_PLAIN_OUT     4'h1
`define MFPC_FN_IRQ_OUT       4'h2
`define MFPC_FN_PDM_CLK_OUT   4'h4
`define MFPC_FN_ADC_PWRDN     4'h7
`define MFPC_FN_BIAS_SWITCH   4'h8
`define MFPC_FN_PLAIN_IN      4'h9
`define MFPC_FN_MCLK_IN       4'hA
`define MFPC_FN_SERIAL_IN     4'hB
`define MFPC_FN_PDM_DATA_A    4'hC
`define MFPC_FN_PDM_DATA_B    4'hD

// Driver codes
`define MFPC_DRV_HIZ          3'h0
`define MFPC_DRV_PUSH_PULL    3'h1
`define MFPC_DRV_LOW_WEAKHI   3'h2
`define MFPC_DRV_LOW_ONLY     3'h3
`define MFPC_DRV_WEAKLO_HIGH  3'h4
`define MFPC_DRV_HIGH_ONLY    3'h5

`endif

// [design/mfpc_pin_driver.v]
// Purpose: Turn a wanted level and a driver style into strong and weak enables for one pin
// Assumes: Pad combines strong and weak drive; strong wins
// Notes: Reserved driver codes leave the pin undriven
`timescale 1ns/1ps
`include "mfpc_defs.vh"

module mfpc_pin_driver (
	// Control
	input  wire       active_in,
	input  wire [2:0] drive_sel_in,
	input  wire       level_in,
	// Pad controls
	output reg        pin_out,
	output reg        pin_oe_out,
	output reg        pin_weak_oe_out
);

	// Strong drive on the level the style allows; weak keeper on the other only in the two weak styles
	always @* begin
		pin_out         = level_in;
		pin_oe_out      = 1'b0;
		pin_weak_oe_out = 1'b0;
		if (active_in) begin
			case (drive_sel_in)
			`MFPC_DRV_PUSH_PULL: begin
				pin_oe_out = 1'b1;
			end
			`MFPC_DRV_LOW_WEAKHI: begin
				pin_oe_out      = ~level_in;
				pin_weak_oe_out = level_in;
			end
			`MFPC_DRV_LOW_ONLY: begin
				pin_oe_out = ~level_in;
			end
			`MFPC_DRV_WEAKLO_HIGH: begin
				pin_oe_out      = level_in;
				pin_weak_oe_out = ~level_in;
			end
			`MFPC_DRV_HIGH_ONLY: begin
				pin_oe_out = level_in;
			end
			default: begin
				pin_oe_out = 1'b0; // Hi-Z and reserved codes
			end
			endcase
		end
	end

endmodule // mfpc_pin_driver

// [design/mfpc_sync3.v]
// Purpose: Three-flop synchroniser with agreement filter for one pin input
// Assumes: Input is asynchronous to mclk_in
// Notes: Output changes only once stages two and three agree
`timescale 1ns/1ps

module mfpc_sync3 (
	// Clock and reset
	input  wire mclk_in,
	input  wire rst_in,
	// Data
	input  wire async_in,
	output reg  level_out
);

	reg s1_q;
	reg s2_q;
	reg s3_q;

	// First stage feeds only the second to keep metastability contained
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			s1_q      <= 1'b0;
			s2_q      <= 1'b0;
			s3_q      <= 1'b0;
			level_out <= 1'b0;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				level_out <= s3_q;
		end
	end

endmodule // mfpc_sync3

// [verification/mfpc_board.sv]
// Purpose: Board net on the bidirectional pin, with an optional outside source
// Assumes: Board source is only enabled while the device leaves the pin to it
// Notes: A net nobody drives toggles each cycle, so a stale level never passes
`timescale 1ns/1ps
module mfpc_board (
	// Clock for the floating pattern
	input  wire mclk_in,
	// Device pad controls
	input  wire bidir_pin_out,
	input  wire bidir_pin_oe_out,
	input  wire bidir_pin_weak_oe_out,
	// Outside source
	input  wire ext_en_in,
	input  wire ext_level_in,
	output wire pad_level_out
);
	logic float_q = 1'b0;
	// Undriven net wanders
	always @(posedge mclk_in) float_q <= ~float_q;
	// Strong drive wins over the source, the source over the weak keeper
	assign pad_level_out = bidir_pin_oe_out ? bidir_pin_out : ext_en_in ? ext_level_in :
		bidir_pin_weak_oe_out ? bidir_pin_out : float_q;
endmodule // mfpc_board

// [verification/mfpc_top_sva.sv]
// Purpose: Port checks for the pin block
// Assumes: Shadow copies of the writable registers follow the write port
// Notes: Role outputs trail the pad by up to five edges
`timescale 1ns/1ps
module mfpc_top_sva (
	// Clock, reset, register port
	input wire       mclk_in,
	input wire       rst_in,
	input wire [7:0] reg_addr_in,
	input wire       reg_wr_in,
	input wire [7:0] reg_wdata_in,
	input wire [7:0] reg_rdata_out,
	// Sources and pads
	input wire       irq_event_in,
	input wire       interrupt_polarity_in,
	input wire       pulse_density_clock_in,
	input wire       bidir_pin_in,
	input wire       bidir_pin_out,
	input wire       bidir_pin_oe_out,
	input wire       bidir_pin_weak_oe_out,
	input wire       out_only_pin_out,
	input wire       out_only_pin_oe_out,
	input wire       out_only_pin_weak_oe_out,
	input wire       adc_powerdown_out
);
	logic [7:0] bcfg_q;
	logic [7:0] ocfg_q;
	logic [7:0] lvl_q;
	// Shadow registers, reserved bits kept at zero
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			bcfg_q <= 8'h22;
			ocfg_q <= 8'h00;
			lvl_q  <= 8'h00;
		end else if (reg_wr_in) begin
			if (reg_addr_in == 8'h21) bcfg_q <= reg_wdata_in & 8'hF7;
			if (reg_addr_in == 8'h22) ocfg_q <= reg_wdata_in & 8'hF7;
			if (reg_addr_in == 8'h29) lvl_q <= reg_wdata_in & 8'hC0;
		end
	end
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	property p_rd_b; reg_addr_in == 8'h21 |-> reg_rdata_out == bcfg_q; endproperty
	a_rd_b: assert property (p_rd_b) else $error("bidir config readback wrong");
	property p_rd_o; reg_addr_in == 8'h22 |-> reg_rdata_out == ocfg_q; endproperty
	a_rd_o: assert property (p_rd_o) else $error("out config readback wrong");
	property p_rd_l; reg_addr_in == 8'h29 |-> reg_rdata_out == lvl_q; endproperty
	a_rd_l: assert property (p_rd_l) else $error("level readback wrong");
	property p_mon0; reg_addr_in == 8'h2A |-> reg_rdata_out[6:0] == 7'h00; endproperty
	a_mon0: assert property (p_mon0) else $error("monitor low bits set");
	property p_dis; bcfg_q[7:4] == 4'h0 |-> !bidir_pin_oe_out && !bidir_pin_weak_oe_out; endproperty
	a_dis: assert property (p_dis) else $error("disabled pin driven");
	property p_gpo; bcfg_q == 8'h11 |-> bidir_pin_oe_out && bidir_pin_out == lvl_q[7]; endproperty
	a_gpo: assert property (p_gpo) else $error("bidir plain output wrong");
	property p_gpo2; ocfg_q == 8'h11 |-> out_only_pin_oe_out && out_only_pin_out == lvl_q[6]; endproperty
	a_gpo2: assert property (p_gpo2) else $error("out pin plain output wrong");
	property p_irq; bcfg_q == 8'h21 |-> bidir_pin_out == (irq_event_in ~^ interrupt_polarity_in); endproperty
	a_irq: assert property (p_irq) else $error("interrupt level wrong");
	property p_pdm; ocfg_q == 8'h41 |-> out_only_pin_out == pulse_density_clock_in; endproperty
	a_pdm: assert property (p_pdm) else $error("pdm clock not passed");
	property p_odr; ocfg_q == 8'h13 && lvl_q[6] |-> !out_only_pin_oe_out && !out_only_pin_weak_oe_out; endproperty
	a_odr: assert property (p_odr) else $error("open drain high driven");
	property p_pd_off; bcfg_q[7:4] != 4'h7 && $past(bcfg_q[7:4]) != 4'h7 |-> !adc_powerdown_out; endproperty
	a_pd_off: assert property (p_pd_off) else $error("powerdown outside role");
	property p_pd_on; (bcfg_q[7:4] == 4'h7 && $stable(bidir_pin_in))[*7] |-> adc_powerdown_out == bidir_pin_in;
	endproperty
	a_pd_on: assert property (p_pd_on) else $error("powerdown not following pin");
	c_gpo: cover property (bcfg_q == 8'h11 && bidir_pin_out);
	c_pd: cover property (adc_powerdown_out);
	c_pdm: cover property (ocfg_q == 8'h41 && out_only_pin_out);
endmodule // mfpc_top_sva
bind mfpc_top mfpc_top_sva u_mfpc_top_sva (.mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
	.reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
	.irq_event_in(irq_event_in), .interrupt_polarity_in(interrupt_polarity_in),
	.pulse_density_clock_in(pulse_density_clock_in), .bidir_pin_in(bidir_pin_in), .bidir_pin_out(bidir_pin_out),
	.bidir_pin_oe_out(bidir_pin_oe_out), .bidir_pin_weak_oe_out(bidir_pin_weak_oe_out),
	.out_only_pin_out(out_only_pin_out), .out_only_pin_oe_out(out_only_pin_oe_out),
	.out_only_pin_weak_oe_out(out_only_pin_weak_oe_out), .adc_powerdown_out(adc_powerdown_out));

// [verification/tb_mfpc_top.sv]
// Purpose: Self-checking bench for the pin block
// Assumes: Inputs change 10 ns after the rising edge
// Notes: Software writes keep reserved function codes out and reserved bits at zero
`timescale 1ns/1ps
module tb_mfpc_top;
	logic        mclk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic [7:0]  reg_addr_in = 8'h00;
	logic        reg_wr_in = 1'b0;
	logic [7:0]  reg_wdata_in = 8'h00;
	logic        irq_event_in = 1'b0;
	logic        interrupt_polarity_in = 1'b0;
	logic        pulse_density_clock_in = 1'b0;
	logic        ext_en = 1'b0;
	logic        ext_lvl = 1'b0;
	wire  [7:0]  reg_rdata_out;
	wire         pad, bo, boe, bwk, oo, ooe, owk;
	wire  [5:0]  roles;
	logic [15:0] bt, ot;
	int          failures = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	// Rows: address, write data, expected readback
	logic [23:0] rows [8] = '{24'h21D5D5, 24'h224545, 24'h29C0C0, 24'h2A8000,
		24'h218484, 24'h221313, 24'h294040, 24'h2B1100};
	// Plain output with no drive stands in for a role that must give no input result
	logic [3:0]  fcode [9] = '{4'h0, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'h1};
	logic [5:0]  fhot [9] = '{6'h00, 6'h20, 6'h10, 6'h00, 6'h08, 6'h04, 6'h02, 6'h01, 6'h00};
	mfpc_top u_mfpc_top (.mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
		.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .irq_event_in(irq_event_in),
		.interrupt_polarity_in(interrupt_polarity_in), .pulse_density_clock_in(pulse_density_clock_in),
		.bidir_pin_in(pad), .bidir_pin_out(bo), .bidir_pin_oe_out(boe), .bidir_pin_weak_oe_out(bwk),
		.out_only_pin_out(oo), .out_only_pin_oe_out(ooe), .out_only_pin_weak_oe_out(owk),
		.adc_powerdown_out(roles[5]), .mic_bias_switch_in_out(roles[4]), .master_clock_out(roles[3]),
		.serial_audio_in_out(roles[2]), .pulse_density_data_a_out(roles[1]), .pulse_density_data_b_out(roles[0]));
	mfpc_board u_mfpc_board (.mclk_in(mclk_in), .bidir_pin_out(bo), .bidir_pin_oe_out(boe),
		.bidir_pin_weak_oe_out(bwk), .ext_en_in(ext_en), .ext_level_in(ext_lvl), .pad_level_out(pad));
	// Free-running clock
	always #50 mclk_in = ~mclk_in;
	// Hang guard, far above the expected run
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			wrap_up();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge mclk_in);
		#10;
	endtask
	// One write, then an idle cycle so the strobe is never raised twice at once
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = 1'b1;
		idle(1);
		reg_wr_in = 1'b0;
		idle(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr_in = a;
		#20;
		chk(reg_rdata_out, exp);
		idle(1);
	endtask
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		idle(20);
		rst_in = 1'b0;
		rd(8'h21, 8'h22);
		rd(8'h22, 8'h00);
		rd(8'h29, 8'h00);
		rd(8'h2A, 8'h00);
		chk({6'h00, ooe, owk}, 8'h00);
		$display("Reset values done");
		for (int i = 0; i < 8; i++) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], rows[i][7:0]);
		end
		$display("Register table done");
		for (int d = 0; d < 8; d++) begin
			for (int lv = 0; lv < 2; lv++) begin
				wr(8'h29, {lv[0], lv[0], 6'h00});
				wr(8'h21, {5'h02, d[2:0]});
				wr(8'h22, {5'h02, d[2:0]});
				bt = lv ? 16'h0A18 : 16'h01A8;
				ot = lv ? 16'h0808 : 16'h0088;
				chk({4'h0, boe, bwk, ooe, owk}, {4'h0, bt[2*d +: 2], ot[2*d +: 2]});
			end
		end
		$display("Drive styles done");
		wr(8'h21, 8'h21);
		wr(8'h22, 8'h21);
		for (int k = 0; k < 4; k++) begin
			{interrupt_polarity_in, irq_event_in} = k[1:0];
			idle(1);
			chk({6'h00, pad, oo}, {6'h00, {2{~^k[1:0]}}});
		end
		wr(8'h21, 8'h41);
		wr(8'h22, 8'h41);
		repeat (4) begin
			pulse_density_clock_in = ~pulse_density_clock_in;
			idle(1);
			chk({6'h00, pad, oo}, {6'h00, {2{pulse_density_clock_in}}});
		end
		$display("Output roles done");
		ext_en = 1'b1;
		for (int i = 0; i < 9; i++) begin
			wr(8'h21, {fcode[i], 4'h0});
			for (int lv = 0; lv < 2; lv++) begin
				ext_lvl = lv[0];
				idle(8);
				chk({2'h0, roles}, lv ? {2'h0, fhot[i]} : 8'h00);
				if (fcode[i] == 4'h9) rd(8'h2A, {lv[0], 7'h00});
			end
		end
		$display("Input roles done");
		rst_in = 1'b1;
		idle(2);
		rst_in = 1'b0;
		rd(8'h21, 8'h22);
		rd(8'h29, 8'h00);
		$display("Second reset done");
		wrap_up();
	end
endmodule // tb_mfpc_top
